// file: design/wdt_pkg.sv
// Package: register map, fields, reset values and divider constants of the watchdog timer
package wdt_pkg;
  localparam logic [7:0]  CTRL_ADDR     = 8'hd3;
  localparam logic [7:0]  COUNT_ADDR    = 8'hfd;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [3:0]  WD_OFF_SIG    = 4'ha;
  localparam int          WD_HI         = 7;
  localparam int          WD_LO         = 4;
  localparam int          CSEL_HI       = 3;
  localparam int          CSEL_LO       = 2;
  localparam int          CNT_CLR_BIT   = 1;
  localparam int          DIV_CLR_BIT   = 0;
  localparam int          POR_STAB_BIT  = 4;
  localparam int          STOP_STAB_BIT = 3;
  localparam int          DIV_W         = 14;
  // Divider tap bit giving one tick per N oscillator cycles
  localparam int          TAP_4096      = 11;
  localparam int          TAP_1024      = 9;
  localparam int          TAP_128       = 6;
  localparam int          TAP_16384     = 13;
  localparam logic [1:0]  SEL_4096      = 2'h0;
  localparam logic [1:0]  SEL_1024      = 2'h1;
  localparam logic [1:0]  SEL_128       = 2'h2;
  localparam logic [1:0]  SEL_16384     = 2'h3;
  localparam logic [DIV_W-1:0] DIV_ZERO = 14'h0000;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [7:0]  BYTE_ONE      = 8'h01;
  localparam logic [7:0]  BYTE_MAX      = 8'hff;

  // Stabilization phases, Gray coded along run -> por -> stop
  typedef enum logic [1:0] {
    WDT_RUN      = 2'b00,
    WDT_STAB_POR = 2'b01,
    WDT_STAB_STP = 2'b11
  } wdt_phase_t;
endpackage : wdt_pkg

// file: design/wdt_tick_if.sv
// Interface: prescaler control and tick between timer core and divider
interface wdt_tick_if;
  logic       clear;
  logic [1:0] sel;
  logic       tick;
  modport core (output clear, output sel, input tick);
  modport div  (input clear, input sel, output tick);
endinterface : wdt_tick_if

// file: design/wdt_prescaler.sv
// Prescaler: free-running oscillator divider with selectable tick tap
module wdt_prescaler (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic ce,
  wdt_tick_if.div   tk
);
  typedef struct packed {
    logic [wdt_pkg::DIV_W-1:0] div;
    logic                      tick;
  } wdt_pre_st_t;

  wdt_pre_st_t s_q;
  wdt_pre_st_t s_d;
  logic [wdt_pkg::DIV_W-1:0] nxt;
  logic [wdt_pkg::DIV_W-1:0] rose;

  // Count and detect the selected tap falling back to zero
  always_comb begin
    s_d  = s_q;
    nxt  = s_q.div + 14'h0001;
    rose = s_q.div & ~nxt;
    case (tk.sel)
      wdt_pkg::SEL_4096:  s_d.tick = rose[wdt_pkg::TAP_4096];
      wdt_pkg::SEL_1024:  s_d.tick = rose[wdt_pkg::TAP_1024];
      wdt_pkg::SEL_128:   s_d.tick = rose[wdt_pkg::TAP_128];
      default:            s_d.tick = rose[wdt_pkg::TAP_16384];
    endcase
    s_d.div = nxt;
    if (tk.clear) begin
      s_d.div  = wdt_pkg::DIV_ZERO;
      s_d.tick = 1'b0;
    end
  end

  // State register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign tk.tick = s_q.tick;
endmodule : wdt_prescaler

// file: design/wdt_core.sv
// Top: watchdog counter unit with control/count registers and stabilization timing
//
// How it works
// - Reset loads control zero: watchdog on, /4096
// - Only upper nibble 1010 disables watchdog
// - Select: 00 /4096, 01 /1024, 10 /128, 11 /16384
// - Counter-clear bit zeroes count, self-clears
// - Divider-clear bit zeroes both prescalers, self-clears
// - Count readable, never loadable
// - Power-on: CPU idle until count bit 4 overflows
// - Stabilization end releases CPU after reset/stop
// - Enabled watchdog acts as automatic reset source
// - Control register read/write at its address
// - Enabled watchdog resets on count bit 7 overflow
// - Stop wake: end stabilization on bit 3 overflow
module wdt_core (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       por_event,
  input  wire logic       stop_wake,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_hit,
  output logic            timer_overflow_signal,
  output logic            wdt_reset_req,
  output logic            cpu_hold,
  output logic            stab_done,
  output logic            other_div_clear
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0]          ctrl;
    logic [7:0]          count;
    wdt_pkg::wdt_phase_t phase;
    logic [7:0]          rdata;
    logic                hit;
    logic                ovf;
    logic                wdt_rst;
    logic                hold;
    logic                done;
    logic                dclr;
    logic                cclr;
  } wdt_core_st_t;

  wdt_core_st_t s_q;
  wdt_core_st_t s_d;
  wdt_tick_if   tk ();
  logic         wr_ctrl;
  logic         wd_en;
  logic [8:0]   inc;

  ////////////////////////////////////////////////////////////////////////////
  wdt_prescaler u_pre (
    .mclk  (mclk),
    .reset (reset),
    .ce    (ce),
    .tk    (tk.div)
  );

  // Divider clear and selection to prescaler
  assign tk.clear = s_q.dclr;
  assign tk.sel   = (s_q.phase == wdt_pkg::WDT_STAB_POR) ? wdt_pkg::SEL_4096
                  : s_q.ctrl[wdt_pkg::CSEL_HI:wdt_pkg::CSEL_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_d     = s_q;
    wr_ctrl = reg_wr && (reg_addr == wdt_pkg::CTRL_ADDR);
    wd_en   = (s_q.ctrl[wdt_pkg::WD_HI:wdt_pkg::WD_LO] != wdt_pkg::WD_OFF_SIG);
    inc     = {1'b0, s_q.count} + 9'h001;
    s_d.ovf     = 1'b0;
    s_d.wdt_rst = 1'b0;
    s_d.done    = 1'b0;
    s_d.dclr    = 1'b0;
    s_d.cclr    = 1'b0;
    s_d.hit     = (reg_rd || reg_wr) &&
                  (reg_addr == wdt_pkg::CTRL_ADDR || reg_addr == wdt_pkg::COUNT_ADDR);

    // Count advance on each prescaler tick
    if (tk.tick) begin
      s_d.count = inc[7:0];
      if (inc[8]) begin
        s_d.ovf = 1'b1;
        if (wd_en && s_q.phase == wdt_pkg::WDT_RUN) begin
          s_d.wdt_rst = 1'b1;
        end
      end
    end

    // Stabilization end detection
    case (s_q.phase)
      wdt_pkg::WDT_STAB_POR: begin
        if (tk.tick && s_q.count[wdt_pkg::POR_STAB_BIT:0] == 5'h1f) begin
          s_d.phase = wdt_pkg::WDT_RUN;
          s_d.done  = 1'b1;
          s_d.count = wdt_pkg::BYTE_ZERO;
        end
      end
      wdt_pkg::WDT_STAB_STP: begin
        if (tk.tick && s_q.count[wdt_pkg::STOP_STAB_BIT:0] == 4'hf) begin
          s_d.phase = wdt_pkg::WDT_RUN;
          s_d.done  = 1'b1;
          s_d.count = wdt_pkg::BYTE_ZERO;
        end
      end
      default: begin
        if (stop_wake) begin
          s_d.phase = wdt_pkg::WDT_STAB_STP;
          s_d.count = wdt_pkg::BYTE_ZERO;
        end
      end
    endcase

    // Control write; clear bits act once and never store
    if (wr_ctrl) begin
      s_d.ctrl = reg_wdata;
      s_d.ctrl[wdt_pkg::CNT_CLR_BIT] = 1'b0;
      s_d.ctrl[wdt_pkg::DIV_CLR_BIT] = 1'b0;
      if (reg_wdata[wdt_pkg::CNT_CLR_BIT]) begin
        s_d.count = wdt_pkg::BYTE_ZERO;
      end
      s_d.dclr = reg_wdata[wdt_pkg::DIV_CLR_BIT];
    end

    // Power-on restarts the stabilization interval
    if (por_event) begin
      s_d.phase = wdt_pkg::WDT_STAB_POR;
      s_d.count = wdt_pkg::BYTE_ZERO;
      s_d.ctrl  = wdt_pkg::CTRL_RESET;
      s_d.dclr  = 1'b1;
    end
    s_d.hold = (s_d.phase != wdt_pkg::WDT_RUN);

    // Read data; count is read-only
    s_d.rdata = wdt_pkg::BYTE_ZERO;
    if (reg_rd && reg_addr == wdt_pkg::CTRL_ADDR) begin
      s_d.rdata = s_q.ctrl;
    end else if (reg_rd && reg_addr == wdt_pkg::COUNT_ADDR) begin
      s_d.rdata = s_q.count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset enters power-on stabilization
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q       <= '0;
      s_q.ctrl  <= wdt_pkg::CTRL_RESET;
      s_q.phase <= wdt_pkg::WDT_STAB_POR;
      s_q.hold  <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign reg_rdata             = s_q.rdata;
  assign reg_hit               = s_q.hit;
  assign timer_overflow_signal = s_q.ovf;
  assign wdt_reset_req         = s_q.wdt_rst;
  assign cpu_hold              = s_q.hold;
  assign stab_done             = s_q.done;
  assign other_div_clear       = s_q.dclr;
endmodule : wdt_core

// file: bench/wdt_checker.sv
// Checker: port assertions of the watchdog timer core
module wdt_checker (
  input wire logic       mclk, reset, ce, reg_wr, reg_rd, reg_hit, timer_overflow_signal,
  input wire logic       wdt_reset_req, cpu_hold, stab_done, other_div_clear,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata
);
  logic ca, ma;
  // Control and mapped address decode
  assign ca = reg_addr == wdt_pkg::CTRL_ADDR;
  assign ma = ca || reg_addr == wdt_pkg::COUNT_ADDR;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////
  property p_hit; ce && (reg_rd || reg_wr) && ma |=> reg_hit; endproperty
  a_hit: assert property (p_hit) else $error("hit missing");
  property p_unmap; ce && reg_rd && !ma |=> reg_rdata == 8'h00 && !reg_hit; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_sclr; ce && reg_rd && ca |=> reg_rdata[1:0] == 2'h0; endproperty
  a_sclr: assert property (p_sclr) else $error("clear bits stuck");
  property p_dclr; ce && reg_wr && ca && reg_wdata[0] |=> other_div_clear; endproperty
  a_dclr: assert property (p_dclr) else $error("no divider clear");
  property p_hold; cpu_hold |-> !wdt_reset_req; endproperty
  a_hold: assert property (p_hold) else $error("reset while holding");
  property p_done; stab_done |-> $past(cpu_hold) ##1 !cpu_hold; endproperty
  a_done: assert property (p_done) else $error("hold not released");
  property p_wdr; wdt_reset_req |-> timer_overflow_signal || $past(timer_overflow_signal); endproperty
  a_wdr: assert property (p_wdr) else $error("reset without overflow");
  property p_ovf; timer_overflow_signal |=> (!timer_overflow_signal) [*8]; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow too soon");
endmodule : wdt_checker
bind wdt_core wdt_checker u_chk (.*);

// file: bench/basic_timer_watchdog_bench.sv
// Testbench: directed scenarios for the watchdog timer core
module basic_timer_watchdog_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CA = wdt_pkg::CTRL_ADDR;
  localparam logic [7:0] NA = wdt_pkg::COUNT_ADDR;
  logic mclk = 1'b0, reset = 1'b1, por_event = 1'b0, stop_wake = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
  logic reg_hit, timer_overflow_signal, wdt_reset_req, cpu_hold, stab_done, other_div_clear;
  logic [2:0] ev;
  int fail_count = 0, samples_checked = 0, n, per[4] = '{4096, 1024, 128, 16384};
  assign ev = {wdt_reset_req, timer_overflow_signal, stab_done};
  wdt_core u_dut (.*, .ce(1'b1));
  // Clock, 100 ns period
  initial forever #50 mclk = ~mclk;
  // Verdict
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // Byte compare and flag compare
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) fail_count++;
    if (g !== e) $display("MISMATCH %0t got %h exp %h", $time, g, e);
  endtask : chk
  task automatic cf(input logic g, input logic e);
    chk({7'h0, g}, {7'h0, e});
  endtask : cf
  // Register cycles, each started at a falling edge; read data lands in v
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge mclk) reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge mclk) {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge mclk) {v, reg_rd} = {reg_rdata, 1'b0};
  endtask : rd
  // Bounded wait for event k, cycles in n
  task automatic wait_for(input int k, input int lim);
    for (n = 0; ev[k] !== 1'b1 && n <= lim; n++) @(negedge mclk);
    cf(n > lim, 1'b0);
    if (n > lim) finish_test();
  endtask : wait_for
  // Reset values, read-only count, unmapped address
  task automatic t_reset;
    rd(CA); chk(v, 8'h00);
    cf(cpu_hold, 1'b1);
    wr(NA, 8'h55); rd(NA); chk(v, 8'h00);
    rd(8'h10); chk(v, 8'h00);
    $display("t_reset end");
  endtask : t_reset
  // Power-on stabilization, 32 ticks at /4096
  task automatic t_por;
    wait_for(0, 140000);
    cf(n > 131040 && n < 131080, 1'b1);
    @(negedge mclk) cf(cpu_hold, 1'b0);
    $display("t_por end");
  endtask : t_por
  // Every clock select, divider clear pulse, self-clearing bits
  task automatic t_sel;
    for (int s = 0; s < 4; s++) begin
      wr(CA, {4'ha, s[1:0], 2'h3}); cf(other_div_clear, 1'b1);
      repeat (per[s] * 3 / 2) @(negedge mclk);
      rd(NA); chk(v, 8'h01);
      rd(CA); chk(v, {4'ha, s[1:0], 2'h0});
    end
    $display("t_sel end");
  endtask : t_sel
  // Overflow with watchdog off, then with another enabling nibble
  task automatic t_wdog;
    wr(CA, 8'hab); wait_for(1, 33000);
    cf(n > 32750 && n < 32780, 1'b1);
    cf(wdt_reset_req, 1'b0);
    @(negedge mclk) cf(wdt_reset_req, 1'b0);
    wr(CA, 8'hbb); wait_for(2, 33000);
    cf(n > 32750 && n < 32780, 1'b1);
    $display("t_wdog end");
  endtask : t_wdog
  // Stop wake, 16 ticks at the selected /128
  task automatic t_stop;
    wr(CA, 8'hab);
    stop_wake = 1'b1;
    @(negedge mclk) stop_wake = 1'b0;
    cf(cpu_hold, 1'b1);
    wait_for(0, 2200); cf(n > 1900 && n < 2060, 1'b1);
    @(negedge mclk) cf(cpu_hold, 1'b0);
    rd(NA); chk(v, 8'h00);
    $display("t_stop end");
  endtask : t_stop
  // Power-on event in mid-run
  task automatic t_pevt;
    @(negedge mclk) por_event = 1'b1;
    @(negedge mclk) por_event = 1'b0;
    cf(cpu_hold, 1'b1);
    rd(CA); chk(v, 8'h00);
    $display("t_pevt end");
  endtask : t_pevt
  // Main sequence
  initial begin
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    t_reset;
    t_por;
    t_sel;
    t_wdog;
    t_stop;
    t_pevt;
    finish_test();
  end
endmodule : basic_timer_watchdog_bench
